// ### ccf_front_end.sv
// card command front end: frame receive, check, decode and card state
// Operation
// RULE_01: ecc selector 0 none, 1 bch three-bit correcting, 2 and 3 reserved
// RULE_02: ecc selector is writable by the user
// RULE_03: hold a seven-bit crc7 checksum of the card data block
// RULE_04: host supplies a matching checksum with new card data
// RULE_05: host is master; card answers only commands needing a reply
// RULE_06: transfers are whole bytes; block lengths are byte counts
// RULE_07: tag bit per sector and group; erase clears tagged units together
// RULE_08: any command except tag or untag clears all tag bits
// RULE_09: host sends erase right after its tag commands
// RULE_10: one write-protect bit per group, set and cleared by commands
// RULE_11: accept indices 0-4,7,9,10,12,13,15,11,16-18
// RULE_12: accept indices 20, 24-27, 28-30, 32-38, 42
// RULE_13: report supported command classes in card data block
// RULE_14: classify each command into four kinds
// RULE_15: frame bits arrive most significant bit first
// RULE_16: frame is 48 bits: start, dir, index, arg, crc, end
// RULE_17: start must be 0 and direction 1, else not a command
// RULE_18: index is binary command number; argument follows the command
// RULE_19: sector 512 bytes, erase group 16 sectors, wp group 2 groups
// RULE_20: block length command argument sets block length
// RULE_21: check frame crc7 over first 40 bits, drop failures
// RULE_22: unsupported indices do nothing except clear tag bits
`timescale 1ns/10ps
module ccf_front_end #(
	parameter int N_SECT   = 64,
	parameter int FIFO_DEPTH = 8
) (
	// clock and reset
	input  wire logic        mclk_i,
	input  wire logic        reset_i,
	// card bus
	input  wire logic        bus_clk_i,
	input  wire logic        cmd_line_i,
	// decoded commands out
	output ccf_pkg::ccf_cmd_s cmd_o,
	output logic             cmd_valid_o,
	input  wire logic        cmd_ready_i,
	// card data block load
	input  wire logic [1:0]  ecc_wr_i,
	input  wire logic [6:0]  crc_wr_i,
	// state out
	output logic [1:0]       ecc_scheme_select_o,
	output logic             ecc_reserved_o,
	output logic [1:0]       ecc_max_fix_o,
	output logic [6:0]       card_data_checksum_o,
	output logic [11:0]      command_class_code_o,
	output logic [31:0]      block_len_o,
	output logic [N_SECT-1:0] sect_tag_o,
	output logic [N_SECT/ccf_pkg::SECT_PER_ERGRP-1:0] grp_tag_o,
	output logic [N_SECT/ccf_pkg::SECT_PER_ERGRP/ccf_pkg::ERGRP_PER_WPGRP-1:0] wp_o,
	output logic [N_SECT-1:0] erase_sel_o,
	output logic             erase_go_o,
	output logic             frame_err_o
);
	localparam int N_GRP = N_SECT / ccf_pkg::SECT_PER_ERGRP;
	localparam int N_WP  = N_GRP / ccf_pkg::ERGRP_PER_WPGRP;
	localparam int SW    = $clog2(N_SECT);
	localparam int GW    = $clog2(N_GRP);
	localparam int WW    = (N_WP > 1) ? $clog2(N_WP) : 1;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b001,
		ST_SHIFT = 3'b010,
		ST_CHECK = 3'b100
	} ccf_st_e;

	// synchronisers for pin inputs
	logic [1:0] clk_sync_r;
	logic [1:0] cmd_sync_r;
	logic       clk_prev_r;
	logic       rise;

	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			clk_sync_r <= 2'h0;
			cmd_sync_r <= 2'h3;
			clk_prev_r <= 1'b0;
		end else begin
			clk_sync_r <= {clk_sync_r[0], bus_clk_i};
			cmd_sync_r <= {cmd_sync_r[0], cmd_line_i};
			clk_prev_r <= clk_sync_r[1];
		end
	end
	// sample on the link clock's rising edge
	assign rise = clk_sync_r[1] && !clk_prev_r;

	// frame receiver
	ccf_st_e    st_r;
	logic [47:0] sh_r;
	logic [5:0] cnt_r;
	logic [6:0] crc_r;
	logic [6:0] crc_nxt;
	logic       good;
	logic       hdr_ok;

	// crc7 over bits as they arrive, x^7+x^3+1
	always_comb begin
		logic fb;
		fb = crc_r[6] ^ cmd_sync_r[1];
		crc_nxt = {crc_r[5:0], 1'b0} ^ (fb ? ccf_pkg::CRC7_POLY : 7'h00); // RULE_21
	end

	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			st_r  <= ST_IDLE;
			sh_r  <= '0;
			cnt_r <= '0;
			crc_r <= '0;
		end else begin
			case (st_r)
				ST_IDLE: begin
					// start bit 0 opens a frame
					if (rise && !cmd_sync_r[1]) begin // RULE_17
						sh_r  <= {47'h0, 1'b0};
						cnt_r <= 6'h01;
						crc_r <= 7'h00; // fresh remainder; a 0 start bit leaves it zero
						st_r  <= ST_SHIFT;
					end
				end
				ST_SHIFT: begin
					if (rise) begin
						sh_r  <= {sh_r[46:0], cmd_sync_r[1]}; // RULE_15
						cnt_r <= cnt_r + 6'h01;
						if (cnt_r < 6'(ccf_pkg::CHK_BITS)) begin
							crc_r <= crc_nxt;
						end
						if (cnt_r == 6'(ccf_pkg::FRAME_BITS - 1)) begin // RULE_16
							st_r <= ST_CHECK;
						end
					end
				end
				ST_CHECK: begin
					st_r <= ST_IDLE;
				end
				default: begin
					st_r <= ST_IDLE;
				end
			endcase
		end
	end

	// frame checks: direction 1, end bit 1, crc matches
	assign hdr_ok = sh_r[46] && sh_r[0]; // RULE_17
	assign good   = (st_r == ST_CHECK) && hdr_ok && (sh_r[7:1] == crc_r); // RULE_21

	logic [5:0]  idx;
	logic [31:0] arg;
	logic        supp;
	logic        is_tag;
	assign idx    = sh_r[45:40]; // RULE_18
	assign arg    = sh_r[39:8];
	assign supp   = ccf_pkg::CMD_SUPPORTED[idx]; // RULE_11 RULE_12 RULE_22
	assign is_tag = (idx == ccf_pkg::CMD_TAG_SECT) || (idx == ccf_pkg::CMD_UNTAG_SECT) ||
		(idx == ccf_pkg::CMD_TAG_GRP) || (idx == ccf_pkg::CMD_UNTAG_GRP);

	// kind classification
	ccf_pkg::ccf_kind_e kind;
	always_comb begin
		case (idx) // RULE_14 RULE_05
			6'h00, 6'h04: kind = ccf_pkg::CCF_BCAST_NO_REPLY;
			6'h01, 6'h02: kind = ccf_pkg::CCF_BCAST_REPLY;
			6'h0B, 6'h11, 6'h12, 6'h14, 6'h18, 6'h19, 6'h1A, 6'h1B,
			6'h1E, 6'h2A: kind = ccf_pkg::CCF_ADDR_DATA;
			default: kind = ccf_pkg::CCF_ADDR_CMD;
		endcase
	end

	// error flag for malformed or bad-crc frames
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			frame_err_o <= 1'b0;
		end else begin
			frame_err_o <= (st_r == ST_CHECK) && !good;
		end
	end

	// decoded command into the fifo; when full the frame is dropped
	ccf_pkg::ccf_cmd_s fifo_in;
	ccf_pkg::ccf_cmd_s fifo_out;
	logic              f_valid;
	assign fifo_in = '{index: idx, arg: arg, kind: kind};

	ccf_fifo #(
		.WIDTH ($bits(ccf_pkg::ccf_cmd_s)),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.mclk_i   (mclk_i),
		.reset_i  (reset_i),
		.wdata_i  (fifo_in),
		.wvalid_i (good && supp),
		.wready_o (),
		.rdata_o  (fifo_out),
		.rvalid_o (f_valid),
		.rready_i (!cmd_valid_o || cmd_ready_i) // pop only when the output stage loads
	);

	// output stage registered so outputs come from flops
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			cmd_o       <= '0;
			cmd_valid_o <= 1'b0;
		end else if (!cmd_valid_o || cmd_ready_i) begin
			cmd_o       <= fifo_out;
			cmd_valid_o <= f_valid;
		end
	end

	// ecc selector and checksum, user programmed
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			ecc_scheme_select_o  <= ccf_pkg::ECC_RESET;
			card_data_checksum_o <= 7'h00;
		end else if (good && idx == ccf_pkg::CMD_PROG_CSD) begin
			ecc_scheme_select_o  <= ecc_wr_i; // RULE_02
			card_data_checksum_o <= crc_wr_i; // RULE_03 RULE_04
		end
	end

	// decode of the ecc selector
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			ecc_reserved_o <= 1'b0;
			ecc_max_fix_o  <= 2'h0;
		end else begin
			ecc_reserved_o <= ecc_scheme_select_o[1]; // RULE_01
			ecc_max_fix_o  <= (ecc_scheme_select_o == ccf_pkg::ECC_BCH) ?
				2'(ccf_pkg::ECC_BCH_BITS) : 2'h0;
		end
	end

	// block length in bytes
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			block_len_o          <= ccf_pkg::BLKLEN_RESET;
			command_class_code_o <= ccf_pkg::CLASS_CODE; // RULE_13
		end else if (good && idx == ccf_pkg::CMD_BLKLEN) begin
			block_len_o <= arg; // RULE_20 RULE_06
		end
	end

	// tags: set/clear by tag commands, cleared by any other command
	logic [SW-1:0] s_ix;
	logic [GW-1:0] g_ix;
	assign s_ix = arg[9+SW-1:9]; // RULE_19
	assign g_ix = arg[13+GW-1:13];

	genvar gi;
	generate
		for (gi = 0; gi < N_SECT; gi++) begin : g_sect
			always_ff @(posedge mclk_i) begin
				if (reset_i) begin
					sect_tag_o[gi] <= 1'b0;
				end else if (good) begin
					if (idx == ccf_pkg::CMD_TAG_SECT && s_ix == SW'(gi)) begin
						sect_tag_o[gi] <= 1'b1; // RULE_07
					end else if (idx == ccf_pkg::CMD_UNTAG_SECT && s_ix == SW'(gi)) begin
						sect_tag_o[gi] <= 1'b0;
					end else if (!is_tag) begin
						sect_tag_o[gi] <= 1'b0; // RULE_08 RULE_22
					end
				end
			end
		end
		for (gi = 0; gi < N_GRP; gi++) begin : g_grp
			always_ff @(posedge mclk_i) begin
				if (reset_i) begin
					grp_tag_o[gi] <= 1'b0;
				end else if (good) begin
					if (idx == ccf_pkg::CMD_TAG_GRP && g_ix == GW'(gi)) begin
						grp_tag_o[gi] <= 1'b1; // RULE_07
					end else if (idx == ccf_pkg::CMD_UNTAG_GRP && g_ix == GW'(gi)) begin
						grp_tag_o[gi] <= 1'b0;
					end else if (!is_tag) begin
						grp_tag_o[gi] <= 1'b0; // RULE_08
					end
				end
			end
		end
		for (gi = 0; gi < N_WP; gi++) begin : g_wp
			always_ff @(posedge mclk_i) begin
				if (reset_i) begin
					wp_o[gi] <= 1'b0;
				end else if (good && WW'(arg[14+WW-1:14]) == WW'(gi)) begin
					if (idx == ccf_pkg::CMD_SET_WP) begin
						wp_o[gi] <= 1'b1; // RULE_10
					end else if (idx == ccf_pkg::CMD_CLR_WP) begin
						wp_o[gi] <= 1'b0;
					end
				end
			end
		end
	endgenerate

	// erase pulse with all tagged sectors selected in parallel
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			erase_go_o  <= 1'b0;
			erase_sel_o <= '0;
		end else begin
			erase_go_o <= good && idx == ccf_pkg::CMD_ERASE; // RULE_07 RULE_09
			for (int s = 0; s < N_SECT; s++) begin
				erase_sel_o[s] <= sect_tag_o[s] || grp_tag_o[s / ccf_pkg::SECT_PER_ERGRP];
			end
		end
	end

	// assertions
	property p_tag_clear;
		@(posedge mclk_i) disable iff (reset_i)
		(good && !is_tag) |=> (sect_tag_o == '0) && (grp_tag_o == '0);
	endproperty
	a_tag_clear: assert property (p_tag_clear) else $error("tags not cleared"); // RULE_08
	property p_bad_dir;
		@(posedge mclk_i) disable iff (reset_i)
		(st_r == ST_CHECK && !sh_r[46]) |=> frame_err_o;
	endproperty
	a_bad_dir: assert property (p_bad_dir) else $error("bad direction accepted"); // RULE_17
	property p_blklen;
		@(posedge mclk_i) disable iff (reset_i)
		(good && idx == ccf_pkg::CMD_BLKLEN) |=> block_len_o == $past(arg);
	endproperty
	a_blklen: assert property (p_blklen) else $error("block length not taken"); // RULE_20
	property p_erase;
		@(posedge mclk_i) disable iff (reset_i)
		(good && idx == ccf_pkg::CMD_ERASE) |=> erase_go_o;
	endproperty
	a_erase: assert property (p_erase) else $error("erase not pulsed"); // RULE_07
	// a stalled consumer must see the same word until it takes it
	sequence s_stalled;
		cmd_valid_o && !cmd_ready_i;
	endsequence
	property p_cmd_hold;
		@(posedge mclk_i) disable iff (reset_i)
		s_stalled |=> cmd_valid_o && $stable(cmd_o);
	endproperty
	a_cmd_hold: assert property (p_cmd_hold) else $error("command dropped while stalled"); // RULE_18
	property p_ecc_load;
		@(posedge mclk_i) disable iff (reset_i)
		(good && idx == ccf_pkg::CMD_PROG_CSD) |=> ecc_scheme_select_o == $past(ecc_wr_i);
	endproperty
	a_ecc_load: assert property (p_ecc_load) else $error("ecc selector not loaded"); // RULE_02
	// check lasts one cycle so the next start bit is never missed
	property p_check_once;
		@(posedge mclk_i) disable iff (reset_i)
		(st_r == ST_CHECK) |=> (st_r == ST_IDLE);
	endproperty
	a_check_once: assert property (p_check_once) else $error("check state stuck"); // RULE_16
endmodule

// ### ccf_pkg.sv
// shared constants and types for the card command front end
package ccf_pkg;

	// frame layout
	localparam int FRAME_BITS     = 48;
	localparam int CHK_BITS       = 40;
	localparam int FRAME_CNT_W    = 6;
	localparam logic [6:0] CRC7_POLY = 7'h09;

	// ecc selector codes
	localparam logic [1:0] ECC_NONE     = 2'h0;
	localparam logic [1:0] ECC_BCH      = 2'h1;
	localparam logic [1:0] ECC_RESET    = 2'h0;
	localparam int         ECC_BCH_BITS = 3;

	// erase geometry
	localparam int SECT_BYTES       = 512;
	localparam int SECT_PER_ERGRP   = 16;
	localparam int ERGRP_PER_WPGRP  = 2;

	// command indices with side effects
	localparam logic [5:0] CMD_BLKLEN   = 6'h10;
	localparam logic [5:0] CMD_SET_WP   = 6'h1C;
	localparam logic [5:0] CMD_CLR_WP   = 6'h1D;
	localparam logic [5:0] CMD_TAG_SECT = 6'h20;
	localparam logic [5:0] CMD_UNTAG_SECT = 6'h21;
	localparam logic [5:0] CMD_TAG_GRP  = 6'h23;
	localparam logic [5:0] CMD_UNTAG_GRP = 6'h24;
	localparam logic [5:0] CMD_ERASE    = 6'h26;
	localparam logic [5:0] CMD_PROG_CSD = 6'h1B;

	// supported set as a 64-bit map, one bit per index
	localparam logic [63:0] CMD_SUPPORTED = 64'h0000_047F_7F17_BE9F;
	localparam logic [11:0] CLASS_CODE    = 12'h0FF;
	localparam logic [31:0] BLKLEN_RESET  = 32'h0000_0200;

	// command kinds
	typedef enum logic [1:0] {
		CCF_BCAST_NO_REPLY = 2'h0,
		CCF_BCAST_REPLY    = 2'h1,
		CCF_ADDR_CMD       = 2'h2,
		CCF_ADDR_DATA      = 2'h3
	} ccf_kind_e;

	// decoded command word
	typedef struct packed {
		logic [5:0]  index;
		logic [31:0] arg;
		ccf_kind_e   kind;
	} ccf_cmd_s;

endpackage

// ### ccf_fifo.sv
// small flop fifo for decoded commands
`timescale 1ns/10ps
module ccf_fifo #(
	parameter int WIDTH = 40,
	parameter int DEPTH = 8
) (
	// clock and reset
	input  wire logic             mclk_i,
	input  wire logic             reset_i,
	// write side
	input  wire logic [WIDTH-1:0] wdata_i,
	input  wire logic             wvalid_i,
	output logic                  wready_o,
	// read side
	output logic [WIDTH-1:0]      rdata_o,
	output logic                  rvalid_o,
	input  wire logic             rready_i
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW-1:0]    wp_r;
	logic [AW-1:0]    rp_r;
	logic [AW:0]      cnt_r;
	logic             push;
	logic             pop;

	assign push     = wvalid_i && (cnt_r != (AW+1)'(DEPTH));
	assign pop      = rvalid_o && rready_i;
	assign wready_o = cnt_r != (AW+1)'(DEPTH);
	assign rvalid_o = cnt_r != '0;
	assign rdata_o  = mem_r[rp_r];

	// storage has no reset, only pointers and fill count
	always_ff @(posedge mclk_i) begin
		if (push) begin
			mem_r[wp_r] <= wdata_i;
		end
	end

	// pointers and fill count
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			wp_r  <= '0;
			rp_r  <= '0;
			cnt_r <= '0;
		end else begin
			if (push) begin
				wp_r <= (wp_r == AW'(DEPTH-1)) ? '0 : wp_r + 1'b1;
			end
			if (pop) begin
				rp_r <= (rp_r == AW'(DEPTH-1)) ? '0 : rp_r + 1'b1;
			end
			cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule

// ### ccf_host_model.sv
// host model driving the card link clock and command line
`timescale 1ns/10ps
module ccf_host_model (
	// card bus
	output logic bus_clk_o,
	output logic cmd_line_o
);
	// link clock stands still low, pulled-up line idles high
	initial begin
		bus_clk_o  = 1'b0;
		cmd_line_o = 1'b1;
	end

	// one frame; bad: 0 good, 1 crc, 2 direction, 3 end bit
	task automatic send(input logic [5:0] idx, input logic [31:0] arg, input int bad);
		logic [47:0] f;
		logic [6:0]  c;
		f = {1'b0, 1'b1, idx, arg, 8'h01};
		c = 7'h00;
		// crc7 over the first 40 bits, generator x^7+x^3+1
		for (int i = 47; i > 7; i--) begin
			c = {c[5:0], 1'b0} ^ (((f[i] ^ c[6]) == 1'b1) ? 7'h09 : 7'h00);
		end
		f[7:1] = c;
		if (bad == 1) f[1] = ~f[1];
		if (bad == 2) f[46] = 1'b0;
		if (bad == 3) f[0] = 1'b0;
		// line changes at the falling edge, card samples at the rising edge
		for (int i = 47; i >= 0; i--) begin
			cmd_line_o <= f[i];
			#400 bus_clk_o <= 1'b1;
			#400 bus_clk_o <= 1'b0;
		end
		cmd_line_o <= 1'b1;
		#1600;
	endtask
endmodule

// ### tb_top.sv
// self-checking bench for the card command front end
`timescale 1ns/10ps
module tb_top;
	logic             mclk_i;
	logic             reset_i;
	logic             bus_clk;
	logic             cmd_line;
	ccf_pkg::ccf_cmd_s cmd_o;
	ccf_pkg::ccf_cmd_s last_cmd;
	logic             cmd_valid_o;
	logic             cmd_ready_i;
	logic [1:0]       ecc_wr_i;
	logic [6:0]       crc_wr_i;
	logic [1:0]       ecc_sel;
	logic             ecc_rsv;
	logic [1:0]       ecc_fix;
	logic [6:0]       csum;
	logic [11:0]      ccc;
	logic [31:0]      blen;
	logic [63:0]      stag;
	logic [3:0]       gtag;
	logic [1:0]       wp;
	logic [63:0]      esel;
	logic [63:0]      ers_sel;
	logic             ers_go;
	logic             ferr;
	int               checks;
	int               fail_count;
	int               n_acc;
	int               n_err;
	int               n_ers;
	int               n;

	ccf_host_model host_u (.bus_clk_o(bus_clk), .cmd_line_o(cmd_line));

	ccf_front_end dut_u (
		.mclk_i(mclk_i), .reset_i(reset_i), .bus_clk_i(bus_clk), .cmd_line_i(cmd_line),
		.cmd_o(cmd_o), .cmd_valid_o(cmd_valid_o), .cmd_ready_i(cmd_ready_i),
		.ecc_wr_i(ecc_wr_i), .crc_wr_i(crc_wr_i), .ecc_scheme_select_o(ecc_sel),
		.ecc_reserved_o(ecc_rsv), .ecc_max_fix_o(ecc_fix), .card_data_checksum_o(csum),
		.command_class_code_o(ccc), .block_len_o(blen), .sect_tag_o(stag),
		.grp_tag_o(gtag), .wp_o(wp), .erase_sel_o(esel), .erase_go_o(ers_go),
		.frame_err_o(ferr)
	);

	// 10 MHz system clock
	always #50 mclk_i = ~mclk_i;

	// count handshakes and pulses; pulses stand one cycle
	always @(posedge mclk_i) begin
		if (cmd_valid_o === 1'b1 && cmd_ready_i === 1'b1) begin
			n_acc++;
			last_cmd = cmd_o;
		end
		if (ferr === 1'b1) n_err++;
		if (ers_go === 1'b1) begin
			n_ers++;
			ers_sel = esel;
		end
	end

	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// send a frame, then let the sync and decode pipeline settle
	task automatic frame(input logic [5:0] idx, input logic [31:0] arg, input int bad);
		host_u.send(idx, arg, bad);
		repeat (10) @(posedge mclk_i);
	endtask

	// {accepted, kind} expected for each index
	function automatic logic [2:0] exp_kind(input int i);
		case (i)
			0, 4: return 3'b100;
			1, 2: return 3'b101;
			3, 7, 9, 10, 12, 13, 15, 16, 28, 29, 32, 33, 34, 35, 36, 37, 38: return 3'b110;
			11, 17, 18, 20, 24, 25, 26, 27, 30, 42: return 3'b111;
			default: return 3'b000;
		endcase
	endfunction

	task automatic t_decode;
		logic [2:0] k;
		for (int i = 0; i < 64; i++) begin
			k = exp_kind(i);
			n = n_acc;
			frame(6'(i), 32'hA5C3_0000 | 32'(i), 0);
			chk(n_acc - n, 64'(k[2]));
			if (k[2]) chk(last_cmd, {6'(i), 32'hA5C3_0000 | 32'(i), k[1:0]});
		end
	endtask

	task automatic t_ecc;
		for (int c = 0; c < 4; c++) begin
			ecc_wr_i <= 2'(c);
			crc_wr_i <= 7'h55 ^ 7'(c);
			frame(ccf_pkg::CMD_PROG_CSD, 32'h0000_0000, 0);
			chk(ecc_sel, 64'(c));
			chk(csum, 64'(7'h55 ^ 7'(c)));
			chk({ecc_rsv, ecc_fix}, (c == 1) ? 3 : ((c > 1) ? 4 : 0));
		end
	endtask

	task automatic t_tag;
		frame(ccf_pkg::CMD_TAG_SECT, 32'h0000_0400, 0);
		frame(ccf_pkg::CMD_TAG_GRP, 32'h0000_2000, 0);
		chk(stag, 64'h0000_0000_0000_0004);
		chk(gtag, 64'h2);
		n = n_ers;
		frame(ccf_pkg::CMD_ERASE, 32'h0000_0000, 0);
		chk(n_ers - n, 1);
		chk(ers_sel, 64'h0000_0000_FFFF_0004);
		chk(stag, 0);
		frame(ccf_pkg::CMD_TAG_SECT, 32'h0000_0600, 0);
		frame(ccf_pkg::CMD_TAG_SECT, 32'h0000_0400, 0);
		frame(ccf_pkg::CMD_UNTAG_SECT, 32'h0000_0600, 0);
		chk(stag, 64'h4);
		frame(6'h0D, 32'h0000_0000, 0);
		chk(stag, 0);
		frame(ccf_pkg::CMD_TAG_GRP, 32'h0000_0000, 0);
		frame(ccf_pkg::CMD_TAG_GRP, 32'h0000_6000, 0);
		frame(ccf_pkg::CMD_UNTAG_GRP, 32'h0000_0000, 0);
		chk(gtag, 64'h8);
		frame(6'h05, 32'h0000_0000, 0);
		chk(gtag, 0);
	endtask

	task automatic t_misc;
		frame(ccf_pkg::CMD_SET_WP, 32'h0000_4000, 0);
		chk(wp, 2);
		frame(ccf_pkg::CMD_CLR_WP, 32'h0000_4000, 0);
		chk(wp, 0);
		frame(ccf_pkg::CMD_BLKLEN, 32'h0000_0040, 0);
		chk(blen, 64'h40);
		// corrupted frames raise the error pulse and are never decoded
		for (int b = 1; b < 4; b++) begin
			n = n_acc;
			frame(6'h0D, 32'h0000_0000, b);
			chk(n_acc - n, 0);
		end
		chk(n_err, 3);
	endtask

	// consumer stalls: eight in the fifo plus one in the output stage, the tenth is dropped
	task automatic t_fifo;
		cmd_ready_i <= 1'b0;
		n = n_acc;
		for (int i = 0; i < 10; i++) frame(6'h0D, 32'(i), 0);
		cmd_ready_i <= 1'b1;
		repeat (20) @(posedge mclk_i);
		chk(n_acc - n, 9);
		chk(last_cmd.arg, 8);
	endtask

	task automatic end_of_test;
		$display("checks %0d fail_count %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// watchdog well beyond the expected run of about 40000 cycles
	initial begin
		#6_000_000;
		fail_count++;
		end_of_test();
	end

	initial begin
		mclk_i = 1'b0;
		reset_i = 1'b1;
		cmd_ready_i = 1'b1;
		ecc_wr_i = 2'h0;
		crc_wr_i = 7'h00;
		repeat (20) @(posedge mclk_i);
		reset_i <= 1'b0;
		@(posedge mclk_i);
		chk(blen, 64'h200);
		chk(ccc, 64'h0FF);
		chk({ecc_sel, csum, wp, gtag}, 0);
		chk(stag, 0);
		t_decode();
		t_ecc();
		t_tag();
		t_misc();
		t_fifo();
		end_of_test();
	end
endmodule
